// ===== verilog/nvss_device.sv
// Device end: sequences save, restore, sleep, wake and standby timing.
// Assumes the host keeps its own wait counters; supply_ok is an async pin.
`timescale 1ns/100ps
`include "nvss_params.svh"

module nvss_device
    import nvss_pkg::*;
#(
    parameter int STORE_CYC   = `NVSS_STORE_CYC,
    parameter int RECALL_CYC  = `NVSS_RECALL_CYC,
    parameter int POWERUP_CYC = `NVSS_POWERUP_CYC,
    parameter int SOFTSEQ_CYC = `NVSS_SOFTSEQ_CYC,
    parameter int SLEEP_CYC   = `NVSS_SLEEP_CYC,
    parameter int WAKE_CYC    = `NVSS_WAKE_CYC,
    parameter int STANDBY_CYC = `NVSS_STANDBY_CYC
) (
    input  wire logic MCLK,
    input  wire logic RSTN,
    nvss_if.device    LINK,
    output logic      PFS_ENABLED,
    output logic      DIRTY,
    output logic      ASLEEP
);
    localparam int CW = `NVSS_CNT_W;

    nvss_dev_state_type      state_ff, nxt_state;
    nvss_dev_state_type      after_ff, nxt_after;
    logic [CW-1:0]           cnt_ff, nxt_cnt;
    logic [CW-1:0]           sb_cnt_ff, nxt_sb_cnt;
    logic                    pfs_en_ff, nxt_pfs_en;
    logic                    dirty_ff, nxt_dirty;
    logic                    standby_ff, nxt_standby;
    logic                    ok_ff, nxt_ok;
    logic [2:0]              sup_sync_ff;
    logic                    sup_ff, nxt_sup;
    logic                    sup_rise;
    logic                    sup_fall;
    logic                    acc_take;

    // Three stages; a change counts only when stages two and three agree.
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            sup_sync_ff <= 3'h0;
        end else begin
            sup_sync_ff <= {sup_sync_ff[1:0], LINK.supply_ok};
        end
    end

    always_comb begin
        nxt_sup = sup_ff;
        if (sup_sync_ff[2] == sup_sync_ff[1]) begin
            nxt_sup = sup_sync_ff[2];
        end
    end

    assign sup_rise = nxt_sup && !sup_ff;
    assign sup_fall = !nxt_sup && sup_ff;
    // Accesses are only honoured in READY, or in the grace window.
    assign acc_take = LINK.acc_req && !LINK.cs_n && sup_ff &&
                      ((state_ff == NVSS_READY) ||
                       (state_ff == NVSS_GRACE));

    always_comb begin
        nxt_state   = state_ff;
        nxt_after   = after_ff;
        nxt_cnt     = cnt_ff;
        nxt_pfs_en  = pfs_en_ff;
        nxt_dirty   = dirty_ff;
        nxt_ok      = 1'b0;
        if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        if (acc_take) begin
            nxt_ok = 1'b1;
            if (LINK.acc_wr) begin
                nxt_dirty = 1'b1;
            end
        end
        case (state_ff)
            NVSS_OFF: begin
                // Supply that came back during a power-fail save has no
                // edge left to see, so a good level restarts the part too.
                if (sup_rise || sup_ff) begin
                    nxt_state = NVSS_RESTORE;
                    nxt_cnt   = CW'(POWERUP_CYC - 1);
                end
            end
            NVSS_RESTORE, NVSS_RECALL, NVSS_SAVE, NVSS_SOFTSEQ,
            NVSS_PFSAVE: begin
                // Save and restore both mark the array clean on completion.
                if (cnt_ff == '0) begin
                    if (state_ff == NVSS_PFSAVE) begin
                        nxt_state = NVSS_OFF;
                    end else begin
                        nxt_state = NVSS_READY;
                    end
                    if (state_ff != NVSS_SOFTSEQ) begin
                        nxt_dirty = 1'b0;
                    end
                end
            end
            NVSS_READY: begin
                if (LINK.cmd_vld && LINK.cmd != `NVSS_CMD_NONE &&
                    LINK.cmd != `NVSS_CMD_WAKE) begin
                    nxt_state = NVSS_GRACE;
                    nxt_after = NVSS_READY;
                    nxt_cnt   = CW'(`NVSS_DELAY_CYC - 1);
                    case (LINK.cmd)
                        `NVSS_CMD_STORE:  nxt_after = NVSS_SAVE;
                        `NVSS_CMD_RECALL: nxt_after = NVSS_RECALL;
                        `NVSS_CMD_SLEEP:  nxt_after = NVSS_SLEEPING;
                        `NVSS_CMD_PFS_EN: begin
                            nxt_after  = NVSS_SOFTSEQ;
                            nxt_pfs_en = 1'b1;
                        end
                        `NVSS_CMD_PFS_DIS: begin
                            nxt_after  = NVSS_SOFTSEQ;
                            nxt_pfs_en = 1'b0;
                        end
                        default: nxt_after = NVSS_READY;
                    endcase
                end
            end
            NVSS_GRACE: begin
                if (cnt_ff == '0) begin
                    nxt_state = after_ff;
                    case (after_ff)
                        NVSS_SAVE:     nxt_cnt = CW'(STORE_CYC - 1);
                        NVSS_RECALL:   nxt_cnt = CW'(RECALL_CYC - 1);
                        NVSS_SOFTSEQ:  nxt_cnt = CW'(SOFTSEQ_CYC - 1);
                        NVSS_SLEEPING: nxt_cnt = CW'(SLEEP_CYC - 1);
                        NVSS_PFSAVE:   nxt_cnt = CW'(STORE_CYC - 1);
                        default:       nxt_cnt = '0;
                    endcase
                end
            end
            NVSS_SLEEPING: begin
                if (cnt_ff == '0) begin
                    nxt_state = NVSS_ASLEEP;
                end
            end
            NVSS_ASLEEP: begin
                if (LINK.cmd_vld && LINK.cmd == `NVSS_CMD_WAKE) begin
                    nxt_state = NVSS_WAKING;
                    nxt_cnt   = CW'(WAKE_CYC - 1);
                end
            end
            NVSS_WAKING: begin
                if (cnt_ff == '0) begin
                    nxt_state = NVSS_READY;
                end
            end
            default: begin
                nxt_state = NVSS_OFF;
            end
        endcase
        // Supply loss overrides everything except an idle, powered-off part.
        if (sup_fall) begin
            if (pfs_en_ff && nxt_dirty) begin
                nxt_state = NVSS_GRACE;
                nxt_after = NVSS_PFSAVE;
                nxt_cnt   = CW'(`NVSS_DELAY_CYC - 1);
            end else begin
                nxt_state = NVSS_OFF;
            end
        end else if (!sup_ff && state_ff == NVSS_GRACE &&
                     after_ff != NVSS_PFSAVE) begin
            nxt_state = NVSS_OFF;
        end
    end

    always_comb begin
        nxt_sb_cnt  = sb_cnt_ff;
        nxt_standby = standby_ff;
        if (!LINK.cs_n) begin
            nxt_sb_cnt  = CW'(STANDBY_CYC - 1);
            nxt_standby = 1'b0;
        end else if (sb_cnt_ff != '0) begin
            nxt_sb_cnt = sb_cnt_ff - 1'b1;
        end else begin
            nxt_standby = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff   <= NVSS_OFF;
            after_ff   <= NVSS_READY;
            cnt_ff     <= '0;
            sb_cnt_ff  <= '0;
            pfs_en_ff  <= 1'b1;
            dirty_ff   <= 1'b0;
            standby_ff <= 1'b1;
            ok_ff      <= 1'b0;
            sup_ff     <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            after_ff   <= nxt_after;
            cnt_ff     <= nxt_cnt;
            sb_cnt_ff  <= nxt_sb_cnt;
            pfs_en_ff  <= nxt_pfs_en;
            dirty_ff   <= nxt_dirty;
            standby_ff <= nxt_standby;
            ok_ff      <= nxt_ok;
            sup_ff     <= nxt_sup;
        end
    end

    assign LINK.acc_ok  = ok_ff;
    assign LINK.busy    = (state_ff != NVSS_READY);
    assign LINK.standby = standby_ff;
    assign PFS_ENABLED  = pfs_en_ff;
    assign DIRTY        = dirty_ff;
    assign ASLEEP       = (state_ff == NVSS_ASLEEP);
endmodule // nvss_device

// ===== verilog/nvss_params.svh
// Timing and code constants shared by both ends of the save/restore sequencer.
// Assumes a 40 MHz MCLK on both ends.
`ifndef NVSS_PARAMS_SVH
`define NVSS_PARAMS_SVH

`define NVSS_CLK_PERIOD_PS        25000
`define NVSS_STORE_TIME_US        8000
`define NVSS_RECALL_TIME_US       600
`define NVSS_POWERUP_TIME_US      20000
`define NVSS_SOFTSEQ_TIME_US      500
`define NVSS_SLEEP_TIME_US        8000
`define NVSS_WAKE_TIME_US         20000
`define NVSS_STANDBY_TIME_US      100
`define NVSS_DELAY_TIME_PS        25000
`define NVSS_CYC_PER_US           (1000000 / `NVSS_CLK_PERIOD_PS)
`define NVSS_STORE_CYC            (`NVSS_STORE_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_RECALL_CYC           (`NVSS_RECALL_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_POWERUP_CYC          (`NVSS_POWERUP_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_SOFTSEQ_CYC          (`NVSS_SOFTSEQ_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_SLEEP_CYC            (`NVSS_SLEEP_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_WAKE_CYC             (`NVSS_WAKE_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_STANDBY_CYC          (`NVSS_STANDBY_TIME_US * `NVSS_CYC_PER_US)
`define NVSS_DELAY_CYC \
    ((`NVSS_DELAY_TIME_PS + `NVSS_CLK_PERIOD_PS - 1) / `NVSS_CLK_PERIOD_PS)
`define NVSS_CNT_W                24

`define NVSS_CMD_NONE             3'h0
`define NVSS_CMD_STORE            3'h1
`define NVSS_CMD_RECALL           3'h2
`define NVSS_CMD_PFS_EN           3'h3
`define NVSS_CMD_PFS_DIS          3'h4
`define NVSS_CMD_SLEEP            3'h5
`define NVSS_CMD_WAKE             3'h6

`endif

// ===== verilog/nvss_pkg.sv
// Types shared by both ends of the save/restore sequencer.
// Assumes nvss_params.svh holds the numeric constants.
package nvss_pkg;
    typedef enum logic [3:0] {
        NVSS_OFF      = 4'h0,
        NVSS_RESTORE  = 4'h1,
        NVSS_READY    = 4'h2,
        NVSS_GRACE    = 4'h3,
        NVSS_SAVE     = 4'h4,
        NVSS_RECALL   = 4'h5,
        NVSS_SOFTSEQ  = 4'h6,
        NVSS_SLEEPING = 4'h7,
        NVSS_ASLEEP   = 4'h8,
        NVSS_WAKING   = 4'h9,
        NVSS_PFSAVE   = 4'hA
    } nvss_dev_state_type;

    typedef enum logic [1:0] {
        NVSS_H_IDLE = 2'h0,
        NVSS_H_SEND = 2'h1,
        NVSS_H_WAIT = 2'h2
    } nvss_host_state_type;
endpackage

// ===== verilog/nvss_if.sv
// Link between the sequencer device end and the host controller end.
// Assumes both ends run on the same MCLK; the bench drives supply_ok.
`timescale 1ns/100ps
interface nvss_if;
    logic       cs_n;
    logic [2:0] cmd;
    logic       cmd_vld;
    logic       acc_req;
    logic       acc_wr;
    logic       acc_ok;
    logic       busy;
    logic       standby;
    logic       supply_ok;

    modport device (
        input  cs_n, cmd, cmd_vld, acc_req, acc_wr, supply_ok,
        output acc_ok, busy, standby
    );
    modport host (
        input  acc_ok, busy, standby,
        output cs_n, cmd, cmd_vld, acc_req, acc_wr
    );
endinterface

// ===== verilog/nvss_host.sv
// Host end: issues commands and accesses, then waits out each interval.
// Assumes the device end shares MCLK; its timing is not trusted, only counted.
`timescale 1ns/100ps
`include "nvss_params.svh"

module nvss_host
    import nvss_pkg::*;
#(
    parameter int STORE_CYC   = `NVSS_STORE_CYC,
    parameter int RECALL_CYC  = `NVSS_RECALL_CYC,
    parameter int POWERUP_CYC = `NVSS_POWERUP_CYC,
    parameter int SOFTSEQ_CYC = `NVSS_SOFTSEQ_CYC,
    parameter int SLEEP_CYC   = `NVSS_SLEEP_CYC,
    parameter int WAKE_CYC    = `NVSS_WAKE_CYC
) (
    input  wire logic       MCLK,
    input  wire logic       RSTN,
    nvss_if.host            LINK,
    input  wire logic       CMD_REQ,
    input  wire logic [2:0] CMD_CODE,
    input  wire logic       ACC_REQ,
    input  wire logic       ACC_WR,
    output logic            READY,
    output logic            ACC_DONE
);
    localparam int CW = `NVSS_CNT_W;

    nvss_host_state_type state_ff, nxt_state;
    logic [CW-1:0]       cnt_ff, nxt_cnt;
    logic [2:0]          cmd_ff, nxt_cmd;
    logic                vld_ff, nxt_vld;
    logic                req_ff, nxt_req;
    logic                wr_ff, nxt_wr;
    logic                cs_n_ff, nxt_cs_n;
    logic                done_ff, nxt_done;

    function automatic logic [CW-1:0] wait_of(input logic [2:0] c);
        case (c)
            `NVSS_CMD_STORE:   wait_of = CW'(STORE_CYC + `NVSS_DELAY_CYC);
            `NVSS_CMD_RECALL:  wait_of = CW'(RECALL_CYC + `NVSS_DELAY_CYC);
            `NVSS_CMD_SLEEP:   wait_of = CW'(SLEEP_CYC + `NVSS_DELAY_CYC);
            `NVSS_CMD_WAKE:    wait_of = CW'(WAKE_CYC + 1);
            default:           wait_of = CW'(SOFTSEQ_CYC + `NVSS_DELAY_CYC);
        endcase
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_cmd   = cmd_ff;
        nxt_vld   = 1'b0;
        nxt_req   = 1'b0;
        nxt_wr    = wr_ff;
        nxt_cs_n  = cs_n_ff;
        nxt_done  = 1'b0;
        if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
        case (state_ff)
            NVSS_H_IDLE: begin
                if (cnt_ff == '0 && CMD_REQ) begin
                    nxt_state = NVSS_H_WAIT;
                    nxt_cmd   = CMD_CODE;
                    nxt_vld   = 1'b1;
                    nxt_cs_n  = 1'b0;
                    nxt_cnt   = wait_of(CMD_CODE);
                end else if (cnt_ff == '0 && ACC_REQ) begin
                    nxt_state = NVSS_H_SEND;
                    nxt_req   = 1'b1;
                    nxt_wr    = ACC_WR;
                    nxt_cs_n  = 1'b0;
                end
            end
            NVSS_H_SEND: begin
                nxt_state = NVSS_H_IDLE;
                nxt_cs_n  = 1'b1;
                nxt_done  = 1'b1;
            end
            NVSS_H_WAIT: begin
                nxt_cs_n = 1'b1;
                // Interval has lapsed by count alone.
                if (cnt_ff == '0) begin
                    nxt_state = NVSS_H_IDLE;
                end
            end
            default: nxt_state = NVSS_H_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= NVSS_H_IDLE;
            cnt_ff   <= CW'(POWERUP_CYC + 4);
            cmd_ff   <= `NVSS_CMD_NONE;
            vld_ff   <= 1'b0;
            req_ff   <= 1'b0;
            wr_ff    <= 1'b0;
            cs_n_ff  <= 1'b1;
            done_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            cmd_ff   <= nxt_cmd;
            vld_ff   <= nxt_vld;
            req_ff   <= nxt_req;
            wr_ff    <= nxt_wr;
            cs_n_ff  <= nxt_cs_n;
            done_ff  <= nxt_done;
        end
    end

    assign LINK.cs_n    = cs_n_ff;
    assign LINK.cmd     = cmd_ff;
    assign LINK.cmd_vld = vld_ff;
    assign LINK.acc_req = req_ff;
    assign LINK.acc_wr  = wr_ff;
    assign READY        = (state_ff == NVSS_H_IDLE) && (cnt_ff == '0);
    assign ACC_DONE     = done_ff;
endmodule // nvss_host

// ===== tb/nvss_properties.sv
// Concurrent checks on the link between the two sequencer ends.
// Assumes the shortened cycle counts that the bench gives both ends.
`timescale 1ns/100ps
`include "nvss_params.svh"
module nvss_properties (
    input wire logic       MCLK,
    input wire logic       RSTN,
    input wire logic       cs_n,
    input wire logic [2:0] cmd,
    input wire logic       cmd_vld,
    input wire logic       acc_req,
    input wire logic       acc_wr,
    input wire logic       acc_ok,
    input wire logic       busy,
    input wire logic       standby,
    input wire logic       supply_ok
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);

    acc_cause_a: assert property (
        acc_ok |-> $past(acc_req) && !$past(cs_n))
        else $error("acc_ok without a selected request");
    low_supply_a: assert property (
        !supply_ok [*6] |-> !acc_ok)
        else $error("access accepted while supply is low");
    store_time_a: assert property (
        cmd_vld && cmd == `NVSS_CMD_STORE && !busy
        |=> busy [*8] ##[25:40] !busy)
        else $error("store busy window out of range");
    recall_time_a: assert property (
        cmd_vld && cmd == `NVSS_CMD_RECALL && !busy
        |=> busy [*4] ##[10:25] !busy)
        else $error("recall busy window out of range");
    softseq_time_a: assert property (
        cmd_vld && !busy &&
        (cmd == `NVSS_CMD_PFS_EN || cmd == `NVSS_CMD_PFS_DIS)
        |=> busy ##[5:20] !busy)
        else $error("soft sequence not finished in time");
    sleep_busy_a: assert property (
        cmd_vld && cmd == `NVSS_CMD_SLEEP && !busy |=> busy [*8])
        else $error("device not busy after sleep command");
    wake_time_a: assert property (
        cmd_vld && cmd == `NVSS_CMD_WAKE |=> busy ##[40:60] !busy)
        else $error("wake not finished in time");
    standby_entry_a: assert property (
        $rose(cs_n) |-> ##[1:10] (standby || !cs_n))
        else $error("standby not entered after deselect");
    restore_time_a: assert property (
        $rose(supply_ok) |=> busy [*8] ##[20:40] !busy)
        else $error("power-up restore window out of range");
    supply_fall_a: assert property (
        $fell(supply_ok) |-> ##[1:6] busy)
        else $error("supply loss did not stop access");

    cover property (cmd_vld && cmd == `NVSS_CMD_STORE);
    cover property (acc_ok && acc_wr);
    cover property ($fell(supply_ok) ##6 busy);
endmodule // nvss_properties

// ===== tb/nvss_bench.sv
// Self-checking bench: host end and device end joined by one link.
// Assumes shortened cycle counts; supply level is driven from here.
`timescale 1ns/100ps
`include "nvss_params.svh"
module nvss_bench;
    import nvss_pkg::*;
    logic       MCLK;
    logic       RSTN;
    logic       cmd_req;
    logic [2:0] cmd_code;
    logic       acc_req;
    logic       acc_wr;
    logic       ready;
    logic       acc_done;
    logic       pfs_enabled;
    logic       dirty;
    logic       asleep;
    int         mismatches;
    int         num_checks;

    // Shortened intervals keep the run small; the checker assumes them.
    localparam int STORE_CYC   = 40;
    localparam int RECALL_CYC  = 20;
    localparam int POWERUP_CYC = 30;
    localparam int SOFTSEQ_CYC = 10;
    localparam int SLEEP_CYC   = 40;
    localparam int WAKE_CYC    = 50;
    localparam int STANDBY_CYC = 8;

    nvss_if link ();
    nvss_device #(.STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC),
        .POWERUP_CYC(POWERUP_CYC), .SOFTSEQ_CYC(SOFTSEQ_CYC),
        .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC),
        .STANDBY_CYC(STANDBY_CYC))
    nvss_device_i (.MCLK(MCLK), .RSTN(RSTN), .LINK(link),
        .PFS_ENABLED(pfs_enabled), .DIRTY(dirty), .ASLEEP(asleep));
    nvss_host #(.STORE_CYC(STORE_CYC), .RECALL_CYC(RECALL_CYC),
        .POWERUP_CYC(POWERUP_CYC), .SOFTSEQ_CYC(SOFTSEQ_CYC),
        .SLEEP_CYC(SLEEP_CYC), .WAKE_CYC(WAKE_CYC))
    nvss_host_i (.MCLK(MCLK), .RSTN(RSTN), .LINK(link), .CMD_REQ(cmd_req),
        .CMD_CODE(cmd_code), .ACC_REQ(acc_req), .ACC_WR(acc_wr),
        .READY(ready), .ACC_DONE(acc_done));
    nvss_properties nvss_properties_i (.MCLK(MCLK), .RSTN(RSTN),
        .cs_n(link.cs_n), .cmd(link.cmd), .cmd_vld(link.cmd_vld),
        .acc_req(link.acc_req), .acc_wr(link.acc_wr), .acc_ok(link.acc_ok),
        .busy(link.busy), .standby(link.standby),
        .supply_ok(link.supply_ok));

    always #12.5 MCLK = ~MCLK;

    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic seen,
                         input logic exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    // Host readiness alone is enough while asleep, since busy stays high.
    task automatic wait_ready(input logic dev);
        int i;
        for (i = 0; i < 300; i++) begin
            if (ready === 1'b1 && (!dev || link.busy === 1'b0)) break;
            tick(1);
        end
        if (i == 300) begin
            mismatches++;
            test_done();
        end
    endtask

    task automatic send_cmd(input logic [2:0] code, input logic dev);
        wait_ready(dev);
        cmd_req = 1'b1;
        cmd_code = code;
        tick(1);
        cmd_req = 1'b0;
        tick(1);
        check("busy", link.busy, 1'b1);
        wait_ready(1'b0);
    endtask

    // Host completion and device acceptance are seen apart, since the host
    // finishes its side whether or not the device honoured the access.
    task automatic access(input logic wr, output logic done,
                          output logic ok);
        done = 1'b0;
        ok = 1'b0;
        acc_req = 1'b1;
        acc_wr = wr;
        tick(1);
        acc_req = 1'b0;
        repeat (6) begin
            tick(1);
            if (acc_done === 1'b1) done = 1'b1;
            if (link.acc_ok === 1'b1) ok = 1'b1;
        end
    endtask

    task automatic t_powerup();
        tick(20);
        check("busy", link.busy, 1'b1);
        check("ready", ready, 1'b0);
        wait_ready(1'b1);
        check("pfs_enabled", pfs_enabled, 1'b1);
    endtask

    task automatic t_write_standby();
        logic done;
        logic ok;
        access(1'b1, done, ok);
        check("acc_done", done, 1'b1);
        check("acc_ok", ok, 1'b1);
        check("standby", link.standby, 1'b0);
        check("dirty", dirty, 1'b1);
        tick(10);
        check("standby", link.standby, 1'b1);
    endtask

    task automatic t_store_recall();
        logic done;
        logic ok;
        send_cmd(`NVSS_CMD_STORE, 1'b1);
        wait_ready(1'b1);
        check("dirty", dirty, 1'b0);
        access(1'b1, done, ok);
        check("acc_ok", ok, 1'b1);
        send_cmd(`NVSS_CMD_RECALL, 1'b1);
        wait_ready(1'b1);
        check("dirty", dirty, 1'b0);
    endtask

    // Power loss must leave the write unsaved with saving disabled, and saved with saving enabled.
    task automatic t_loss(input logic [2:0] code, input logic exp_dirty);
        logic done;
        logic ok;
        send_cmd(code, 1'b1);
        wait_ready(1'b1);
        check("pfs_enabled", pfs_enabled, code == `NVSS_CMD_PFS_EN);
        access(1'b1, done, ok);
        check("acc_ok", ok, 1'b1);
        link.supply_ok = 1'b0;
        tick(80);
        check("dirty", dirty, exp_dirty);
        access(1'b1, done, ok);
        check("acc_ok", ok, 1'b0);
        check("dirty", dirty, exp_dirty);
        link.supply_ok = 1'b1;
        wait_ready(1'b1);
        check("dirty", dirty, 1'b0);
    endtask

    task automatic t_sleep_wake();
        send_cmd(`NVSS_CMD_SLEEP, 1'b1);
        check("asleep", asleep, 1'b1);
        send_cmd(`NVSS_CMD_WAKE, 1'b0);
        wait_ready(1'b1);
        check("asleep", asleep, 1'b0);
    endtask

    initial begin
        MCLK = 1'b0;
        RSTN = 1'b0;
        cmd_req = 1'b0;
        cmd_code = `NVSS_CMD_NONE;
        acc_req = 1'b0;
        acc_wr = 1'b0;
        link.supply_ok = 1'b1;
        mismatches = 0;
        num_checks = 0;
        tick(4);
        RSTN = 1'b1;
        t_powerup();
        t_write_standby();
        t_store_recall();
        t_loss(`NVSS_CMD_PFS_DIS, 1'b1);
        t_loss(`NVSS_CMD_PFS_EN, 1'b0);
        t_sleep_wake();
        test_done();
    end
endmodule // nvss_bench
